// File: hdl/hot_swap_regs.svh
/*
  Named constants of the hot swap fault sequencer: clock rate, time base,
  default interval lengths, retry limit and field widths.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef HOT_SWAP_REGS_SVH
`define HOT_SWAP_REGS_SVH

// ============================================================
// clock and time base
`define CLK_PERIOD_NS   8
`define TICK_NS         1000
`define PRE_W           12

// ============================================================
// default intervals, in microseconds of the time base, and the duty ratio in percent
`define T_FLT_US        1550
`define T_POR_US        1550
`define T_LIMITON_US    14000
`define DUTY_PCT        3
`define PCT_FULL        100

// ============================================================
// counters and widths
`define RETRY_LIMIT     7
`define CNT_W           3
`define TIMER_W         20
`define SEL_W           2
`define SYNC_STAGES     2

`endif

// File: hdl/hot_swap_pkg.sv
/*
  Types shared by the hot swap fault sequencer modules.
  Assumes hot_swap_regs.svh is on the include path.
*/
`default_nettype none
`include "hot_swap_regs.svh"

package hot_swap_pkg;

  // gray coded along disabled -> delay -> run -> limit -> off -> latched
  typedef enum logic [2:0] {
    ST_DISABLED = 3'h0,
    ST_POR_WAIT = 3'h1,
    ST_RUN      = 3'h3,
    ST_LIMIT    = 3'h2,
    ST_OFF      = 3'h6,
    ST_LATCHED  = 3'h7
  } seq_state_t;

  typedef logic [`TIMER_W-1:0] ticks_t;
  typedef logic [`CNT_W-1:0]   fault_cnt_t;
  typedef logic [`SEL_W-1:0]   timing_sel_t;

endpackage : hot_swap_pkg

`default_nettype wire

// File: hdl/window_if.sv
/*
  Carrier between the sequencer and one window glitch filter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface window_if;
  import hot_swap_pkg::*;
  logic   tick;
  ticks_t filtLen;
  logic   level;
  logic   fault;

  modport filt (input tick, input filtLen, input level, output fault);
  modport user (output tick, output filtLen, output level, input fault);
endinterface : window_if

`default_nettype wire

// File: hdl/window_filter.sv
/*
  Glitch filter for one window comparator: the faulting level must last
  filtLen time-base ticks before it is reported; recovery passes at once.
  Assumes level is already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module window_filter
  import hot_swap_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  window_if.filt   win
);

  ticks_t cnt_ff;
  ticks_t nxt_cnt;
  logic   fault_ff;
  logic   nxt_fault;

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_fault = fault_ff;
    if (!win.level) begin
      nxt_cnt   = '0;                                   // R12
      nxt_fault = 1'h0;                                 // R12
    end else if (!fault_ff && win.tick) begin
      if (cnt_ff + ticks_t'(1) >= win.filtLen) begin
        nxt_fault = 1'h1;                               // R12
      end else begin
        nxt_cnt = cnt_ff + ticks_t'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff   <= '0;
      fault_ff <= 1'h0;
    end else begin
      cnt_ff   <= nxt_cnt;
      fault_ff <= nxt_fault;
    end
  end

  assign win.fault = fault_ff;

  // ============================================================
  // checks
  a_recover_immediate: assert property (@(posedge clk) disable iff (sys_rst) // R12
    !win.level |=> !fault_ff) else $error("filter held a fault after recovery");

  a_fault_after_filter: assert property (@(posedge clk) disable iff (sys_rst) // R12
    $rose(fault_ff) |-> $past(win.level) && ($past(cnt_ff) + ticks_t'(1) >= win.filtLen))
    else $error("fault reported before the filter time");

endmodule : window_filter

`default_nettype wire

// File: hdl/hot_swap_fault_sequencer.sv
/*
  Sequencing and fault logic of a negative-rail hot swap controller:
  power-on delay, hold in current limit, timed retry, consecutive-fault
  latch-off and window fault handling, all timed from one time base.
  Assumes comparator outputs and the timing setting arrive asynchronously;
  the analog gate drive follows gateEnable and gateHold.
*/
// Behaviour
// [R1] after the window is entered, wait the power-on delay before ramping the gate
// [R2] while current is at the limit, hold the gate drive constant
// [R3] when current falls below the limit, release the hold and ramp on
// [R4] overvoltage forces the gate low; restore once it falls below release level
// [R5] undervoltage forces the gate low; restore only above the rising threshold
// [R6] current limit lasting past the limit-on time registers a current fault
// [R7] after a current fault, keep the gate low for the off time, then retry
// [R8] limit-on time is three percent of the retry off time
// [R9] count consecutive current faults; latch off on the seventh until power cycles
// [R10] a clean restart after the off time clears the fault counter
// [R11] current glitches shorter than limit-on time only hold the gate, no fault
// [R12] filter only faulting window edges by the glitch time; recover at once
// [R13] below supply lockout stay disabled with gate low; enable above it
// [R14] all intervals scale together from one timing setting; setting zero is default
// [R15] synchronise comparator inputs; each interval is a cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "hot_swap_regs.svh"

module hot_swap_fault_sequencer
  import hot_swap_pkg::*;
#(
  parameter int TICK_CYC   = `TICK_NS / `CLK_PERIOD_NS,
  parameter int FLT_TICKS  = `T_FLT_US,
  parameter int POR_TICKS  = `T_POR_US,
  parameter int LIM_TICKS  = `T_LIMITON_US,
  parameter int OFF_TICKS  = `T_LIMITON_US * `PCT_FULL / `DUTY_PCT
)(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  uvLowIn,
  input  wire logic                  ovHighIn,
  input  wire logic                  limitIn,
  input  wire logic                  lockoutIn,
  input  wire hot_swap_pkg::timing_sel_t timingSel,
  output var  logic                  gateEnable,
  output var  logic                  gateHold,
  output var  logic                  latchedOff,
  output var  hot_swap_pkg::fault_cnt_t faultCount
);
  import hot_swap_pkg::*;

  localparam int NSYNC = 4 + `SEL_W;

  // ============================================================
  // input synchronisers
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncA_ff;
  logic [NSYNC-1:0] syncB_ff;

  assign rawIn = {timingSel, lockoutIn, limitIn, ovHighIn, uvLowIn};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          syncA_ff[gi] <= 1'h0;
          syncB_ff[gi] <= 1'h0;
        end else begin
          syncA_ff[gi] <= rawIn[gi];                    // R15
          syncB_ff[gi] <= syncA_ff[gi];                 // R15
        end
      end
    end
  endgenerate

  logic        uvS;
  logic        ovS;
  logic        limS;
  logic        lkoS;
  timing_sel_t selS;
  timing_sel_t selLast_ff;
  timing_sel_t sel_ff;
  timing_sel_t nxt_sel;

  assign uvS  = syncB_ff[0];
  assign ovS  = syncB_ff[1];
  assign limS = syncB_ff[2];
  assign lkoS = syncB_ff[3];
  assign selS = sel_ff;

  // ============================================================
  // common time base, stretched by the timing setting
  logic [`PRE_W-1:0] pre_ff;
  logic [`PRE_W-1:0] nxt_pre;
  logic [`PRE_W-1:0] preTerm;
  logic              tick_ff;
  logic              nxt_tick;

  // setting zero gives the default intervals; n stretches them by n+1
  assign preTerm = `PRE_W'(TICK_CYC * (int'(selS) + 1) - 1);   // R14

  always_comb begin
    nxt_tick = 1'h0;
    nxt_pre  = pre_ff + `PRE_W'(1);
    // a new setting counts only once two samples agree, so its bits never mix
    nxt_sel  = (syncB_ff[NSYNC-1:4] == selLast_ff) ? selLast_ff : sel_ff;   // R14
    if (pre_ff >= preTerm) begin
      nxt_pre  = '0;
      nxt_tick = 1'h1;                                  // R14
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_ff     <= '0;
      tick_ff    <= 1'h0;
      selLast_ff <= '0;
      sel_ff     <= '0;
    end else begin
      pre_ff     <= nxt_pre;
      tick_ff    <= nxt_tick;
      selLast_ff <= syncB_ff[NSYNC-1:4];
      sel_ff     <= nxt_sel;
    end
  end

  // ============================================================
  // window glitch filters, undervoltage then overvoltage
  window_if winIf [2] ();
  logic [1:0] winLevel;
  logic [1:0] winFlt;
  logic       winFault;

  assign winLevel = {ovS, uvS};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_win
      assign winIf[gi].tick    = tick_ff;
      assign winIf[gi].filtLen = ticks_t'(FLT_TICKS);
      assign winIf[gi].level   = winLevel[gi];
      assign winFlt[gi]        = winIf[gi].fault;
      window_filter u_filt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .win     (winIf[gi])
      );
    end
  endgenerate

  assign winFault = |winFlt;

  // ============================================================
  // sequencer
  seq_state_t state_ff;
  seq_state_t nxt_state;
  ticks_t     timer_ff;
  ticks_t     nxt_timer;
  ticks_t     term;
  logic       done;
  fault_cnt_t cnt_ff;
  fault_cnt_t nxt_cnt;
  logic       gateEn_ff;
  logic       hold_ff;
  logic       latch_ff;
  logic       nxt_gateEn;
  logic       nxt_hold;
  logic       nxt_latch;

  always_comb begin
    case (state_ff)
      ST_POR_WAIT: term = ticks_t'(POR_TICKS);          // R1
      ST_RUN:      term = ticks_t'(LIM_TICKS);          // R10
      ST_LIMIT:    term = ticks_t'(LIM_TICKS);          // R6
      ST_OFF:      term = ticks_t'(OFF_TICKS);          // R7 R8
      default:     term = '1;
    endcase
  end

  assign done = (timer_ff >= term);                     // R15

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_timer = (tick_ff && !done) ? timer_ff + ticks_t'(1) : timer_ff;
    if (lkoS) begin
      nxt_state = ST_DISABLED;                          // R13
      nxt_cnt   = '0;                                   // R9
    end else begin
      case (state_ff)
        ST_DISABLED: begin
          if (!winFault) nxt_state = ST_POR_WAIT;       // R1 R4 R5
        end
        ST_POR_WAIT: begin
          if (winFault) nxt_state = ST_DISABLED;
          else if (done) nxt_state = ST_RUN;            // R1
        end
        ST_RUN: begin
          if (winFault) nxt_state = ST_DISABLED;        // R4 R5
          else if (limS) nxt_state = ST_LIMIT;          // R2
          else if (done) nxt_cnt = '0;                  // R10
        end
        ST_LIMIT: begin
          if (winFault) begin
            nxt_state = ST_DISABLED;
          end else if (!limS) begin
            nxt_state = ST_RUN;                         // R3 R11
          end else if (done) begin
            nxt_cnt   = cnt_ff + fault_cnt_t'(1);       // R6 R9
            nxt_state = (cnt_ff + fault_cnt_t'(1) == fault_cnt_t'(`RETRY_LIMIT)) ?
                        ST_LATCHED : ST_OFF;            // R9
          end
        end
        ST_OFF: begin
          if (winFault) nxt_state = ST_DISABLED;
          else if (done) nxt_state = ST_RUN;            // R7
        end
        ST_LATCHED: nxt_state = ST_LATCHED;             // R9
        default: nxt_state = ST_DISABLED;
      endcase
    end
    if (nxt_state != state_ff) nxt_timer = '0;
    nxt_gateEn = (nxt_state == ST_RUN) || (nxt_state == ST_LIMIT);   // R1 R7
    nxt_hold   = (nxt_state == ST_LIMIT);                            // R2
    nxt_latch  = (nxt_state == ST_LATCHED);                          // R9
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff  <= ST_DISABLED;
      timer_ff  <= '0;
      cnt_ff    <= '0;
      gateEn_ff <= 1'h0;
      hold_ff   <= 1'h0;
      latch_ff  <= 1'h0;
    end else begin
      state_ff  <= nxt_state;
      timer_ff  <= nxt_timer;
      cnt_ff    <= nxt_cnt;
      gateEn_ff <= nxt_gateEn;
      hold_ff   <= nxt_hold;
      latch_ff  <= nxt_latch;
    end
  end

  assign gateEnable = gateEn_ff;
  assign gateHold   = hold_ff;
  assign latchedOff = latch_ff;
  assign faultCount = cnt_ff;

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_lockout_gate_low: assert property (lkoS |=> !gateEn_ff && state_ff == ST_DISABLED) // R13
    else $error("gate enabled under supply lockout");
  a_por_delay_wait: assert property ((state_ff == ST_POR_WAIT && !done) |=> !gateEn_ff) // R1
    else $error("gate ramped before the power-on delay");
  a_limit_hold_gate: assert property (
    (state_ff == ST_RUN && limS && !winFault && !lkoS) |=> hold_ff && gateEn_ff) // R2
    else $error("no hold while current at the limit");
  a_hold_release: assert property (
    (state_ff == ST_LIMIT && !limS && !winFault && !lkoS) |=> !hold_ff && gateEn_ff) // R3
    else $error("hold not released below the limit");
  a_ov_gate_low: assert property (winFlt[1] |=> !gateEn_ff) // R4
    else $error("gate on during overvoltage");
  a_uv_gate_low: assert property (winFlt[0] |=> !gateEn_ff) // R5
    else $error("gate on during undervoltage");
  a_fault_register: assert property (
    (state_ff == ST_LIMIT && done && limS && !winFault && !lkoS)
      |=> cnt_ff == $past(cnt_ff) + fault_cnt_t'(1) && !gateEn_ff) // R6
    else $error("current fault not registered at limit-on expiry");
  a_retry_after_off: assert property (
    (state_ff == ST_OFF && done && !winFault && !lkoS) |=> state_ff == ST_RUN) // R7
    else $error("no retry after the off time");
  a_duty_ratio: assert property (
    (OFF_TICKS * `DUTY_PCT <= LIM_TICKS * `PCT_FULL) &&
    (LIM_TICKS * `PCT_FULL < OFF_TICKS * `DUTY_PCT + `DUTY_PCT)) // R8
    else $error("limit-on to off ratio is not the duty figure");
  a_latch_holds: assert property ((state_ff == ST_LATCHED && !lkoS) |=> latch_ff && !gateEn_ff) // R9
    else $error("latched shutdown left without a power cycle");
  a_counter_clear: assert property (
    (state_ff == ST_RUN && done && !limS && !winFault && !lkoS) |=> cnt_ff == '0) // R10
    else $error("fault counter not cleared after clean run");
  a_glitch_no_fault: assert property (
    (state_ff == ST_LIMIT && !done && !lkoS) |=> cnt_ff == $past(cnt_ff)) // R11
    else $error("short current glitch counted as fault");

  c_latch_off: cover property (state_ff == ST_LIMIT ##1 state_ff == ST_LATCHED);
  c_retry_run: cover property (state_ff == ST_OFF ##1 state_ff == ST_RUN);
  c_hold_release: cover property (state_ff == ST_LIMIT ##1 state_ff == ST_RUN);
  c_window_drop: cover property (state_ff == ST_RUN ##1 state_ff == ST_DISABLED);

endmodule : hot_swap_fault_sequencer

`default_nettype wire

// File: sim/gate_load_model.sv
/*
  Behavioural pass FET with its current-sense comparator, far side of the sequencer.
  Assumes gateEnable and gateHold come from the sequencer and shortOn from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module gate_load_model (
  input  wire logic clk,
  input  wire logic gateEnable,
  input  wire logic gateHold,
  input  wire logic shortOn,
  output var  logic limitIn
);
  // ============================================================
  // gate drive in steps: ramps while enabled and not held, drops at once when disabled
  logic [3:0] level_ff = 4'h0;

  always @(negedge clk) begin
    if (!gateEnable) begin
      level_ff <= 4'h0;
    end else if (!gateHold && level_ff != 4'hF) begin
      level_ff <= level_ff + 4'h1;
    end
  end

  // sense reaches the limit only into a short with enough gate drive
  always_comb limitIn = shortOn && (level_ff >= 4'h4);
endmodule : gate_load_model

`default_nettype wire

// File: sim/hot_swap_fault_sequencer_tb.sv
/*
  Self-checking bench of the hot swap fault sequencer, shortened intervals.
  Assumes the sequencer and gate_load_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module hot_swap_fault_sequencer_tb;
  import hot_swap_pkg::*;
  // ============================================================
  // stimulus and wiring
  typedef struct {logic uv; logic ov; int len; logic gate;} row_t;
  logic        clk = 1'b0;
  logic        sysRst;
  logic        uvLow;
  logic        ovHigh;
  logic        limitIn;
  logic        lockout;
  logic        shortOn;
  timing_sel_t timingSel;
  logic        gateEnable;
  logic        gateHold;
  logic        latchedOff;
  fault_cnt_t  faultCount;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n;
  int          d0;
  int          d1;
  row_t        rows[4] = '{'{1'b1, 1'b0, 2, 1'b1}, '{1'b0, 1'b1, 2, 1'b1},
                           '{1'b1, 1'b0, 12, 1'b0}, '{1'b0, 1'b1, 12, 1'b0}};

  always #4 clk = ~clk;

  hot_swap_fault_sequencer #(.TICK_CYC(1), .FLT_TICKS(3), .POR_TICKS(4), .LIM_TICKS(10),
    .OFF_TICKS(333)) i_hot_swap_fault_sequencer (
    .clk(clk), .sys_rst(sysRst), .uvLowIn(uvLow), .ovHighIn(ovHigh), .limitIn(limitIn),
    .lockoutIn(lockout), .timingSel(timingSel), .gateEnable(gateEnable),
    .gateHold(gateHold), .latchedOff(latchedOff), .faultCount(faultCount));

  gate_load_model i_gate_load_model (.clk(clk), .gateEnable(gateEnable),
    .gateHold(gateHold), .shortOn(shortOn), .limitIn(limitIn));

  // ============================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // waits for gateEnable (sel 0) or gateHold (sel 1) to reach val, bounded
  task automatic wait_on(input bit sel, input logic val, input int lim, output int cnt);
    cnt = 0;
    while ((sel ? gateHold : gateEnable) !== val && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    chk(sel ? "gateHold" : "gateEnable", val, sel ? gateHold : gateEnable);
  endtask : wait_on

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #(8 * 10000);
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end

  // ============================================================
  // main sequence
  initial begin
    sysRst = 1'b1;
    {uvLow, ovHigh, lockout, shortOn} = 4'h0;
    timingSel = 2'h0;
    cyc(5);
    chk("gateEnable", 0, gateEnable);
    chk("faultCount", 0, faultCount);
    sysRst = 1'b0;
    cyc(4);
    chk("gateEnable", 0, gateEnable);
    wait_on(0, 1'b1, 30, n);
    // window faults and glitches
    foreach (rows[i]) begin
      uvLow = rows[i].uv;
      ovHigh = rows[i].ov;
      cyc(rows[i].len);
      chk("gateEnable", rows[i].gate, gateEnable);
      {uvLow, ovHigh} = 2'h0;
      cyc(3);
      chk("gateEnable", rows[i].gate, gateEnable);
      wait_on(0, 1'b1, 30, n);
    end
    // short current glitch: hold and release, no fault
    shortOn = 1'b1;
    wait_on(1, 1'b1, 6, n);
    cyc(3);
    shortOn = 1'b0;
    wait_on(1, 1'b0, 6, n);
    cyc(12);
    chk("faultCount", 0, faultCount);
    chk("gateEnable", 1, gateEnable);
    // one fault, cured during the off time
    shortOn = 1'b1;
    wait_on(1, 1'b1, 6, n);
    wait_on(0, 1'b0, 20, n);
    cyc(2);
    chk("faultCount", 1, faultCount);
    shortOn = 1'b0;
    wait_on(0, 1'b1, 400, n);
    cyc(15);
    chk("faultCount", 0, faultCount);
    // permanent short: seven faults then latch off
    shortOn = 1'b1;
    for (int k = 1; k <= 7; k++) begin
      wait_on(1, 1'b1, 12, n);
      wait_on(0, 1'b0, 20, n);
      chk("holdTime", 1, n >= 8 && n <= 14);
      cyc(2);
      chk("faultCount", k, faultCount);
      if (k < 7) begin
        wait_on(0, 1'b1, 400, n);
        chk("offTime", 1, n + 2 >= 332 && n + 2 <= 340);
      end
    end
    chk("latchedOff", 1, latchedOff);
    cyc(400);
    chk("gateEnable", 0, gateEnable);
    // supply lockout clears the latch and restarts
    shortOn = 1'b0;
    lockout = 1'b1;
    cyc(4);
    chk("gateEnable", 0, gateEnable);
    lockout = 1'b0;
    cyc(3);
    chk("latchedOff", 0, latchedOff);
    chk("faultCount", 0, faultCount);
    wait_on(0, 1'b1, 30, d0);
    // doubled time base stretches the power-on delay
    timingSel = 2'h1;
    lockout = 1'b1;
    cyc(4);
    chk("gateEnable", 0, gateEnable);
    lockout = 1'b0;
    wait_on(0, 1'b1, 40, d1);
    chk("scaledDelay", 1, d1 - d0 >= 3 && d1 - d0 <= 7);
    complete_run();
  end
endmodule : hot_swap_fault_sequencer_tb

`default_nettype wire
